// [src/clock_pll_pkg.sv]
/*
 * Shared definitions for the reference clock and PLL control block:
 * field positions of the clock configuration register, its reset value,
 * input mode codes and the packed carriers used at the block ports.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package clock_pll_pkg;

    // Register geometry
    localparam int          CFG_WIDTH        = 16;
    localparam logic [15:0] CFG_RESET        = 16'h0020;

    // Field positions inside clock_pll_control
    localparam int          OUT_DIV2_BIT     = 15;
    localparam int          FB_DIV2_BIT      = 14;
    localparam int          FB_N_MSB         = 13;
    localparam int          FB_N_LSB         = 9;
    localparam int          MODE_MSB         = 7;
    localparam int          MODE_LSB         = 5;
    localparam int          PLL_PWRDN_BIT    = 5;
    localparam int          LOW_RANGE_BIT    = 4;
    localparam int          REF_DIV2_BIT     = 3;
    localparam int          VCO_ALT_BIT      = 2;
    localparam int          PLL_RESETN_BIT   = 1;
    localparam int          LOCK_BIT         = 0;

    // Input mode field codes
    localparam logic [1:0]  MODE_XTAL_PLL    = 2'h2;
    localparam logic [1:0]  MODE_XTAL_BYP    = 2'h3;
    localparam logic [2:0]  MODE_DIFF_PLL    = 3'h0;
    localparam logic [2:0]  MODE_DIFF_BYP    = 3'h1;
    localparam logic [2:0]  MODE_CMOS_PLL    = 3'h4;
    localparam logic [2:0]  MODE_CMOS_BYP    = 3'h5;

    // Feedback divider: a zero N field stands for this count
    localparam logic [5:0]  FB_N_ZERO_COUNT  = 6'h20;

    // Factor is reported in quarters (0.25 .. 64)
    localparam int          FACTOR_WIDTH     = 9;
    localparam int          FACTOR_FRAC_BITS = 2;

    typedef enum logic [1:0] {
        REF_DIFF,
        REF_XTAL,
        REF_CMOS
    } ref_mode_type;

    // Decoded controls towards the analog clock path
    typedef struct packed {
        ref_mode_type ref_mode;
        logic         pll_enable;
        logic         pll_power_down;
        logic         pll_reset_n;
        logic         pll_low_range;
        logic         ref_div2;
        logic         vco_alt;
        logic         out_div2;
        logic         fb_div2;
        logic [4:0]   fb_n;
    } clk_ctrl_type;

    localparam clk_ctrl_type CTRL_RESET = '{
        ref_mode:       REF_DIFF,
        pll_enable:     1'b0,
        pll_power_down: 1'b1,
        pll_reset_n:    1'b0,
        pll_low_range:  1'b0,
        ref_div2:       1'b0,
        vco_alt:        1'b0,
        out_div2:       1'b0,
        fb_div2:        1'b0,
        fb_n:           5'h00
    };

endpackage : clock_pll_pkg

// [src/lock_synchronizer.sv]
/*
 * Two-flop synchroniser for a single asynchronous level.
 * Assumes the clock is free running and the input is a slow level.
 */
`timescale 1ns/1ps
`default_nettype none

module lock_synchronizer (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic async_in,
    output var  logic sync_out
);

    logic first_stage;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            first_stage <= 1'b0;
            sync_out    <= 1'b0;
        end else begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end

endmodule : lock_synchronizer

`default_nettype wire

// [src/ref_clock_pll_select_control.sv]
/*
 * Clock configuration register and system clock selection for the DDS
 * clock path: decodes input mode, PLL power, reset, range, dividers and
 * VCO choice, reports lock, and picks reference or PLL as system clock.
 * Assumes a single-cycle write strobe on ref_clk and an asynchronous
 * lock level from the analog PLL; the glitch-free mux sits outside.
 * A write reaches the stored word on the taking edge and every output
 * one edge later; a lock change needs three edges to show.
 * No address decode: the block holds a single register.
 */
`timescale 1ns/1ps
`default_nettype none

module ref_clock_pll_select_control (
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    input  wire logic                                cfg_write,
    input  wire logic [clock_pll_pkg::CFG_WIDTH-1:0] cfg_wdata,
    output var  logic [clock_pll_pkg::CFG_WIDTH-1:0] cfg_rdata,
    input  wire logic                                pll_lock_raw,
    output var  clock_pll_pkg::clk_ctrl_type         clk_ctrl,
    output var  logic [clock_pll_pkg::FACTOR_WIDTH-1:0] mult_quarters,
    output var  logic                                system_clock_from_pll,
    output var  logic                                lock_lost
);

    // Stored writable bits; bit 0 is never stored
    logic [clock_pll_pkg::CFG_WIDTH-1:0]    cfg;
    logic [clock_pll_pkg::CFG_WIDTH-1:0]    next_cfg;
    logic                                   lock_sync;
    logic                                   prev_lock;
    // Next values, one per registered output
    logic [clock_pll_pkg::CFG_WIDTH-1:0]    next_cfg_rdata;
    clock_pll_pkg::clk_ctrl_type            next_clk_ctrl;
    logic [clock_pll_pkg::FACTOR_WIDTH-1:0] next_mult_quarters;
    logic                                   next_system_clock_from_pll;
    logic                                   next_lock_lost;
    // Decode scratch, settled within each cycle
    logic [2:0]                             mode;
    logic [5:0]                             n_eff;
    logic [clock_pll_pkg::FACTOR_WIDTH-1:0] factor;

    // Lock level brought into the ref_clk domain
    // Only the second stage is read; the first may still be settling
    lock_synchronizer u_lock_sync (
        .clk      (ref_clk),
        .resetn   (resetn),
        .async_in (pll_lock_raw),
        .sync_out (lock_sync)
    );

    // Register write: lock bit position never takes write data
    // Writes may come on back-to-back cycles; the last one wins
    always_comb begin
        next_cfg = cfg;
        if (cfg_write) begin
            next_cfg = cfg_wdata;
            next_cfg[clock_pll_pkg::LOCK_BIT] = 1'b0;
        end
    end

    // Read view: stored bits plus live synchronised lock
    // Bit 0 is never stored, so a write cannot fake a lock
    always_comb begin
        next_cfg_rdata = cfg;
        next_cfg_rdata[clock_pll_pkg::LOCK_BIT] = lock_sync;
    end

    // Input mode and PLL enable decode
    // Bit 5 is both the mode LSB and the PLL power-down, so every
    // bypass code also powers the loop down
    always_comb begin
        mode = cfg[clock_pll_pkg::MODE_MSB:clock_pll_pkg::MODE_LSB];
        next_clk_ctrl = clock_pll_pkg::CTRL_RESET;
        if (mode[1:0] == clock_pll_pkg::MODE_XTAL_PLL) begin
            next_clk_ctrl.ref_mode   = clock_pll_pkg::REF_XTAL;
            next_clk_ctrl.pll_enable = 1'b1;
        end else if (mode[1:0] == clock_pll_pkg::MODE_XTAL_BYP) begin
            next_clk_ctrl.ref_mode   = clock_pll_pkg::REF_XTAL;
            next_clk_ctrl.pll_enable = 1'b0;
        end else begin
            // Top bit now picks CMOS over differential
            case (mode)
                clock_pll_pkg::MODE_DIFF_PLL: begin
                    next_clk_ctrl.ref_mode   = clock_pll_pkg::REF_DIFF;
                    next_clk_ctrl.pll_enable = 1'b1;
                end
                clock_pll_pkg::MODE_DIFF_BYP: begin
                    next_clk_ctrl.ref_mode   = clock_pll_pkg::REF_DIFF;
                    next_clk_ctrl.pll_enable = 1'b0;
                end
                clock_pll_pkg::MODE_CMOS_PLL: begin
                    next_clk_ctrl.ref_mode   = clock_pll_pkg::REF_CMOS;
                    next_clk_ctrl.pll_enable = 1'b1;
                end
                clock_pll_pkg::MODE_CMOS_BYP: begin
                    next_clk_ctrl.ref_mode   = clock_pll_pkg::REF_CMOS;
                    next_clk_ctrl.pll_enable = 1'b0;
                end
                // Codes x10 and x11 were taken above
                default: begin
                    next_clk_ctrl.ref_mode   = clock_pll_pkg::REF_DIFF;
                    next_clk_ctrl.pll_enable = 1'b0;
                end
            endcase
        end
        // Individual PLL controls
        next_clk_ctrl.pll_power_down = cfg[clock_pll_pkg::PLL_PWRDN_BIT];
        next_clk_ctrl.pll_reset_n    = cfg[clock_pll_pkg::PLL_RESETN_BIT];
        next_clk_ctrl.pll_low_range  = cfg[clock_pll_pkg::LOW_RANGE_BIT];
        next_clk_ctrl.ref_div2       = cfg[clock_pll_pkg::REF_DIV2_BIT];
        next_clk_ctrl.vco_alt        = cfg[clock_pll_pkg::VCO_ALT_BIT];
        next_clk_ctrl.out_div2       = cfg[clock_pll_pkg::OUT_DIV2_BIT];
        next_clk_ctrl.fb_div2        = cfg[clock_pll_pkg::FB_DIV2_BIT];
        next_clk_ctrl.fb_n = cfg[clock_pll_pkg::FB_N_MSB:clock_pll_pkg::FB_N_LSB];
    end

    // Multiplication factor in quarters
    // Quarter units keep both halvings exact down to 0.25x
    // Reset shows zero; the real factor follows one edge after release
    always_comb begin
        n_eff = {1'b0, cfg[clock_pll_pkg::FB_N_MSB:clock_pll_pkg::FB_N_LSB]};
        if (n_eff == 6'h00) begin
            n_eff = clock_pll_pkg::FB_N_ZERO_COUNT;
        end
        factor = {1'b0, n_eff, 2'h0};
        if (cfg[clock_pll_pkg::FB_DIV2_BIT]) begin
            factor = {factor[clock_pll_pkg::FACTOR_WIDTH-2:0], 1'b0};
        end
        if (cfg[clock_pll_pkg::OUT_DIV2_BIT]) begin
            factor = {1'b0, factor[clock_pll_pkg::FACTOR_WIDTH-1:1]};
        end
        if (cfg[clock_pll_pkg::REF_DIV2_BIT]) begin
            factor = {1'b0, factor[clock_pll_pkg::FACTOR_WIDTH-1:1]};
        end
        next_mult_quarters = factor;
    end

    // System clock source and lock loss event
    // A synchronised level steers the external glitch-free switch, so a
    // lock change takes effect three reference edges late
    always_comb begin
        // PLL only when enabled, powered, out of reset and locked
        next_system_clock_from_pll = next_clk_ctrl.pll_enable
                                   && !cfg[clock_pll_pkg::PLL_PWRDN_BIT]
                                   && cfg[clock_pll_pkg::PLL_RESETN_BIT]
                                   && lock_sync;
        // One-cycle pulse when lock drops under a PLL selection
        // prev_lock resets low like an unlocked loop: no false edge
        next_lock_lost = prev_lock && !lock_sync
                       && next_clk_ctrl.pll_enable;
    end

    // Register stages; each only stores what its comb process computed, except prev_lock, which stores lock_sync

    // Stored configuration word
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg <= clock_pll_pkg::CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Read view; bit 0 trails the synchroniser by one edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata <= clock_pll_pkg::CFG_RESET;
        end else begin
            cfg_rdata <= next_cfg_rdata;
        end
    end

    // Decoded controls towards the analog clock path
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clk_ctrl <= clock_pll_pkg::CTRL_RESET;
        end else begin
            clk_ctrl <= next_clk_ctrl;
        end
    end

    // Multiplication factor
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mult_quarters <= '0;
        end else begin
            mult_quarters <= next_mult_quarters;
        end
    end

    // Clock source, lock loss pulse and lock history
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            system_clock_from_pll <= 1'b0;
            lock_lost             <= 1'b0;
            prev_lock             <= 1'b0;
        end else begin
            system_clock_from_pll <= next_system_clock_from_pll;
            lock_lost             <= next_lock_lost;
            prev_lock             <= lock_sync;
        end
    end

endmodule : ref_clock_pll_select_control

`default_nettype wire

// [test/clock_pll_properties.sv]
/* Port checker for the clock control block.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module clock_pll_checker (
    input wire logic                        ref_clk,
    input wire logic                        resetn,
    input wire logic                        cfg_write,
    input wire logic [15:0]                 cfg_wdata,
    input wire logic [15:0]                 cfg_rdata,
    input wire logic                        pll_lock_raw,
    input wire clock_pll_pkg::clk_ctrl_type clk_ctrl,
    input wire logic [8:0]                  mult_quarters,
    input wire logic                        system_clock_from_pll,
    input wire logic                        lock_lost
);
    logic [5:0] n_eff;
    logic [8:0] exp_q;
    // Factor in quarters from the stored fields
    assign n_eff = (cfg_rdata[13:9] == 5'h00) ? 6'h20 : {1'h0, cfg_rdata[13:9]};
    assign exp_q = ({3'h0, n_eff} << (2 + cfg_rdata[14]))
                   >> ({1'h0, cfg_rdata[15]} + {1'h0, cfg_rdata[3]});
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence write_alone; cfg_write ##1 !cfg_write; endsequence
    sequence lock_fall; $fell(cfg_rdata[0]); endsequence
    chk_write_store: assert property (
        write_alone |-> ##1 cfg_rdata[15:1] == $past(cfg_wdata[15:1], 2))
        else $error("stored word differs");
    chk_xtal_decode: assert property (
        cfg_rdata[6] |-> clk_ctrl.ref_mode == clock_pll_pkg::REF_XTAL
        && clk_ctrl.pll_enable == !cfg_rdata[5]) else $error("crystal decode");
    chk_diff_cmos: assert property (
        !cfg_rdata[6] |-> clk_ctrl.pll_enable == !cfg_rdata[5] && clk_ctrl.ref_mode
        == (cfg_rdata[7] ? clock_pll_pkg::REF_CMOS : clock_pll_pkg::REF_DIFF))
        else $error("diff or cmos decode");
    chk_field_map: assert property (
        {clk_ctrl.out_div2, clk_ctrl.fb_div2, clk_ctrl.fb_n, clk_ctrl.pll_power_down,
         clk_ctrl.pll_low_range, clk_ctrl.ref_div2, clk_ctrl.vco_alt,
         clk_ctrl.pll_reset_n} == {cfg_rdata[15:9], cfg_rdata[5:1]})
        else $error("control field map");
    chk_factor_value: assert property (
        $past(resetn) |-> mult_quarters == exp_q) else $error("factor value");
    chk_lock_view: assert property (
        pll_lock_raw [*4] |-> cfg_rdata[0]) else $error("lock bit stale");
    chk_pll_select: assert property (
        system_clock_from_pll == (clk_ctrl.pll_enable && !clk_ctrl.pll_power_down
        && clk_ctrl.pll_reset_n && cfg_rdata[0])) else $error("clock select");
    chk_lost_pulse: assert property (
        lock_lost |-> lock_fall ##1 !lock_lost) else $error("loss pulse shape");
    chk_lost_cause: assert property (
        lock_fall ##0 clk_ctrl.pll_enable |-> lock_lost) else $error("loss missed");
endmodule : clock_pll_checker
bind ref_clock_pll_select_control clock_pll_checker u_chk (.ref_clk, .resetn,
    .cfg_write, .cfg_wdata, .cfg_rdata, .pll_lock_raw, .clk_ctrl, .mult_quarters,
    .system_clock_from_pll, .lock_lost);
`default_nettype wire

// [test/pll_lock_model.sv]
/* Lock source standing in for the analog loop.
   Runs on ref_clk; the bench may hold it out of lock. */
`timescale 1ns/1ps
`default_nettype none
module pll_lock_model #(parameter int LOCK_CYCLES = 10) (
    input  wire logic                        ref_clk,
    input  wire clock_pll_pkg::clk_ctrl_type clk_ctrl,
    input  wire logic                        hold_off,
    output var  logic                        pll_lock_raw
);
    int count = 0;
    // Acquire only while powered, released and enabled
    always @(posedge ref_clk) begin
        if (hold_off || !clk_ctrl.pll_enable || clk_ctrl.pll_power_down
            || !clk_ctrl.pll_reset_n) begin
            count <= 0;
        end else if (count < LOCK_CYCLES) begin
            count <= count + 1;
        end
    end
    assign pll_lock_raw = (count == LOCK_CYCLES);
endmodule : pll_lock_model
`default_nettype wire

// [test/ref_clock_pll_select_control_tb.sv]
/* Self-checking bench for the clock control block.
   Inputs change at the falling edge; notes are compared as results land. */
`timescale 1ns/1ps
`default_nettype none
module ref_clock_pll_select_control_tb;
    typedef struct packed {int due; logic [15:0] rd; logic [8:0] mq;
                           logic [1:0] md;} note_type;
    logic ref_clk = 1'b0, resetn = 1'b0, cfg_write = 1'b0, hold_off = 1'b1;
    logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, w;
    logic pll_lock_raw, system_clock_from_pll, lock_lost;
    logic [8:0] mult_quarters;
    clock_pll_pkg::clk_ctrl_type clk_ctrl;
    int bad_count = 0, num_checks = 0, cyc = 0, seed = 32'h1950;
    note_type notes[$];
    ref_clock_pll_select_control u_dut (.ref_clk, .resetn, .cfg_write, .cfg_wdata,
        .cfg_rdata, .pll_lock_raw, .clk_ctrl, .mult_quarters, .system_clock_from_pll,
        .lock_lost);
    pll_lock_model u_lock (.ref_clk, .clk_ctrl, .hold_off, .pll_lock_raw);
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Expected view of a written word, lock held off
    function automatic note_type expect_of(input logic [15:0] v, input int due);
        note_type n;
        int q;
        q = (v[13:9] == 5'h00) ? 32 : int'(v[13:9]);
        q = q * (v[14] ? 8 : 4) / (v[15] ? 2 : 1) / (v[3] ? 2 : 1);
        n.due = due;
        n.rd = {v[15:1], 1'b0};
        n.mq = q[8:0];
        n.md = v[6] ? clock_pll_pkg::REF_XTAL
               : (v[7] ? clock_pll_pkg::REF_CMOS : clock_pll_pkg::REF_DIFF);
        return n;
    endfunction : expect_of
    task automatic write_reg(input logic [15:0] v);
        @(negedge ref_clk);
        cfg_write = 1'b1;
        cfg_wdata = v;
        notes.push_back(expect_of(v, cyc + 2));
    endtask : write_reg
    // Idle cycle with junk on the data lines
    task automatic idle();
        @(negedge ref_clk);
        cfg_write = 1'b0;
        cfg_wdata = 16'($random(seed));
    endtask : idle
    // Wait for the select (0) or the loss pulse (1), bounded by lim
    task automatic wait_for(input int lim, input bit for_loss);
        for (int k = 0; k < lim && (for_loss ? lock_lost : system_clock_from_pll) !== 1'b1;
             k++) @(negedge ref_clk);
    endtask : wait_for
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // Take the oldest note when its result is due
    always @(negedge ref_clk) begin
        if (notes.size() > 0 && notes[0].due == cyc) begin
            check("cfg_rdata", notes[0].rd, cfg_rdata);
            check("mult_quarters", {7'h0, notes[0].mq}, mult_quarters);
            check("ref_mode", {14'h0, notes[0].md}, {14'h0, clk_ctrl.ref_mode});
            void'(notes.pop_front());
        end
    end
    initial begin
        #(2000 * 50);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) resetn = 1'b1;
        notes.push_back(expect_of(clock_pll_pkg::CFG_RESET, cyc + 1));
        for (int i = 0; i < 8; i++) begin
            w = 16'($random(seed));
            w[7:5] = i[2:0];
            write_reg(w);
            idle();
        end
        write_reg(16'hffff);
        write_reg(16'h4000);
        write_reg(16'h0001);
        repeat (4) idle();
        hold_off = 1'b0;
        write_reg(16'h0a02);
        idle();
        wait_for(30, 1'b0);
        check("pll select", 16'h1, {15'h0, system_clock_from_pll});
        check("lock bit", 16'h1, {15'h0, cfg_rdata[0]});
        hold_off = 1'b1;
        wait_for(8, 1'b1);
        check("lock lost", 16'h1, {15'h0, lock_lost});
        idle();
        check("fallback", 16'h0, {lock_lost, system_clock_from_pll});
        hold_off = 1'b0;
        wait_for(30, 1'b0);
        check("relock", 16'h1, {15'h0, system_clock_from_pll});
        resetn = 1'b0;
        #1;
        check("reset word", 16'h0020, cfg_rdata);
        check("pll off", 16'h1, {15'h0, clk_ctrl.pll_power_down});
        repeat (2) idle();
        resetn = 1'b1;
        notes.push_back(expect_of(clock_pll_pkg::CFG_RESET, cyc + 1));
        repeat (3) idle();
        close_out();
    end
endmodule : ref_clock_pll_select_control_tb
`default_nettype wire
